// File: rcwd_pkg.sv
/*
  Constants and types shared by the reset cause and wake delay block.
  Assumes a 200 MHz core clock; the lock, CPU-ready and oscillator-stable counts derive from that rate.
*/
package rcwd_pkg;

  // Register map (word index on the plain port)
  localparam logic [1:0] ADDR_RESET_CAUSE = 2'h0;
  localparam logic [1:0] ADDR_WAKE_CTRL = 2'h1;
  localparam logic [1:0] ADDR_WAKE_STATUS = 2'h2;

  // Reset cause and control bit positions
  localparam int BIT_IRQ_PRIO = 7;
  localparam int BIT_SOFT_BOR = 6;
  localparam int BIT_RESET_INSTR = 4;
  localparam int BIT_WDOG_EXPIRY = 3;
  localparam int BIT_POWER_DOWN = 2;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;

  // Brown-out configuration that hands bit 6 to software
  localparam logic [1:0] BOR_CFG_SOFTWARE = 2'h1;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int OST_CYCLES = 1024;
  localparam int PLL_LOCK_US = 2000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;
  localparam int CPU_READY_NS = 100;
  localparam int CPU_READY_CYCLES = (CPU_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int IOSC_STABLE_NS = 1000;
  localparam int IOSC_STABLE_CYCLES = (IOSC_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PIN_FILTER_CYCLES = 8;

  // Clock sources
  typedef enum logic [2:0] {
    RCWD_SRC_CRYSTAL = 3'b000,
    RCWD_SRC_CRYSTAL_PLL = 3'b001,
    RCWD_SRC_EXT_CLOCK = 3'b010,
    RCWD_SRC_INT_OSC = 3'b011,
    RCWD_SRC_SECONDARY = 3'b100,
    RCWD_SRC_INT_31KHZ = 3'b101,
    RCWD_SRC_NONE = 3'b110
  } rcwd_src_t;

  typedef enum logic [2:0] {
    RCWD_ST_IDLE = 3'b000,
    RCWD_ST_OST = 3'b001,
    RCWD_ST_PLL = 3'b010,
    RCWD_ST_IOSC = 3'b011,
    RCWD_ST_DONE = 3'b100
  } rcwd_state_t;

endpackage

// File: rcwd_delay_if.sv
/*
  Carrier between the wake sequencer and its countdown timer.
  Assumes one clock and synchronous use by both parties.
*/
`timescale 1ns/10ps
interface rcwd_delay_if;
  logic load;
  logic [19:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

// File: rcwd_timer.sv
/*
  Loadable down-counter used for start-up, lock and stabilisation waits.
  Assumes an asynchronous active-low reset whose release is already synchronised to clk.
*/
`timescale 1ns/10ps
module rcwd_timer (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Delay port
  rcwd_delay_if.timer dly
);
  logic [19:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 20'h0_0000;
      run_reg <= 1'b0;
    end else if (ce) begin
      if (dly.load) begin
        cnt_reg <= dly.count;
        run_reg <= 1'b1;
      end else if (run_reg && cnt_reg != 20'h0_0000) begin
        cnt_reg <= cnt_reg - 20'h0_0001;
      end
    end
  end

  assign dly.expired = run_reg && (cnt_reg == 20'h0_0000) && !dly.load;
endmodule // rcwd_timer

// File: rcwd_top.sv
/*
  Reset cause tracking and wake-up exit delay sequencing.
  Assumes firmware on the plain register port and board logic on the reset pin.
*/
`timescale 1ns/10ps
module rcwd_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Configuration
  input wire logic [1:0] brownout_config,
  input wire logic external_reset_pin_enable,
  // Reset events
  input wire logic power_on_event,
  input wire logic brownout_event,
  input wire logic reset_instr_event,
  input wire logic watchdog_timeout,
  input wire logic stack_full_event,
  input wire logic stack_underflow_event,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic power_managed,
  // Reset pin
  input wire logic external_reset_pin,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  output logic pin_digital_in,
  // Wake sequencing
  input wire logic wake_event,
  input wire logic primary_idle_mode,
  input wire logic [2:0] src_before,
  input wire logic [2:0] src_after,
  output logic cpu_run,
  output logic primary_clock_ready,
  output logic internal_osc_stable,
  output logic soft_brownout_enable,
  output logic irq_priority_enable,
  output logic device_reset_req,
  output logic [7:0] reset_cause_onehot
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] pin_sync_reg;
  logic [3:0] filt_cnt_reg;
  logic pin_low_reg;
  logic irq_prio_reg;
  logic soft_bor_reg;
  logic reset_instr_flag_reg;
  logic watchdog_expiry_flag_reg;
  logic power_down_flag_reg;
  logic power_on_flag_reg;
  logic brownout_flag_reg;
  logic soft_bor_en;
  logic pending_reg;
  logic [7:0] cause_next;
  logic [7:0] cause_reg;
  logic [7:0] episode_reg;
  logic [7:0] reset_cause_control_read;
  logic [5:0] cpu_cnt_reg;
  rcwd_pkg::rcwd_state_t state_reg;
  rcwd_pkg::rcwd_src_t after_src;
  logic wr_reset_cause_control;

  rcwd_delay_if dly ();

  rcwd_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .dly(dly)
  );

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_reg <= 2'h3;
    end else if (ce) begin
      pin_sync_reg <= {pin_sync_reg[0], external_reset_pin};
    end
  end

  // Glitch filter: low must persist before it counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_reg <= 4'h0;
      pin_low_reg <= 1'b0;
    end else if (ce) begin
      if (pin_sync_reg[1] || !external_reset_pin_enable) begin
        filt_cnt_reg <= 4'h0;
        pin_low_reg <= 1'b0;
      end else if (filt_cnt_reg == 4'(rcwd_pkg::PIN_FILTER_CYCLES - 1)) begin
        pin_low_reg <= 1'b1;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 4'h1;
      end
    end
  end

  // Pin is input only; reads as data when reset function is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe <= 1'b0;
      pin_digital_in <= 1'b0;
    end else if (ce) begin
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe <= 1'b0;
      pin_digital_in <= external_reset_pin_enable ? 1'b0 : pin_sync_reg[1];
    end
  end

  // Cause capture: seven sources in eight cause bits, applied as one pending reset
  always_comb begin
    cause_next = 8'h00;
    cause_next[0] = power_on_event;
    cause_next[1] = pin_low_reg && !power_managed;
    cause_next[2] = pin_low_reg && power_managed;
    cause_next[3] = watchdog_timeout && !power_managed;
    cause_next[4] = brownout_event && soft_bor_en;
    cause_next[5] = reset_instr_event;
    cause_next[6] = stack_full_event;
    cause_next[7] = stack_underflow_event;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 8'h00;
      episode_reg <= 8'h00;
      pending_reg <= 1'b0;
    end else if (ce) begin
      if (cause_next != 8'h00) begin
        cause_reg <= cause_reg | cause_next;
        episode_reg <= episode_reg | cause_next;
        pending_reg <= 1'b1;
      end else if (pending_reg) begin
        episode_reg <= 8'h00;
        pending_reg <= 1'b0;
      end
    end
  end

  // Brown-out enable follows config; software bit only in mode 01
  assign soft_bor_en = (brownout_config == rcwd_pkg::BOR_CFG_SOFTWARE) ? soft_bor_reg
                       : (brownout_config != 2'h0);
  assign wr_reset_cause_control = reg_wr && reg_addr == rcwd_pkg::ADDR_RESET_CAUSE;

  // Control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_prio_reg <= 1'b0;
      soft_bor_reg <= 1'b1;
    end else if (ce) begin
      if (pending_reg && cause_next == 8'h00) begin
        irq_prio_reg <= 1'b0;
        soft_bor_reg <= 1'b1;
      end else if (wr_reset_cause_control) begin
        irq_prio_reg <= reg_wdata[rcwd_pkg::BIT_IRQ_PRIO];
        soft_bor_reg <= reg_wdata[rcwd_pkg::BIT_SOFT_BOR];
      end
    end
  end

  // Flags: hardware clears at reset release, firmware sets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_instr_flag_reg <= 1'b1;
      power_on_flag_reg <= 1'b0;
      brownout_flag_reg <= 1'b0;
    end else if (ce) begin
      // Only this reset's causes; an old power-on must not clear flags again
      if (pending_reg && cause_next == 8'h00) begin
        if (episode_reg[5]) begin
          reset_instr_flag_reg <= 1'b0;
        end
        if (episode_reg[0]) begin
          power_on_flag_reg <= 1'b0;
        end
        if (episode_reg[4] || episode_reg[0]) begin
          brownout_flag_reg <= 1'b0;
        end
      end else if (wr_reset_cause_control) begin
        reset_instr_flag_reg <= reset_instr_flag_reg | reg_wdata[rcwd_pkg::BIT_RESET_INSTR];
        power_on_flag_reg <= power_on_flag_reg | reg_wdata[rcwd_pkg::BIT_POWER_ON];
        brownout_flag_reg <= brownout_flag_reg | reg_wdata[rcwd_pkg::BIT_BROWNOUT];
      end
    end
  end

  // Read-only watchdog and power-down flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expiry_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end else if (ce) begin
      if (watchdog_timeout) begin
        watchdog_expiry_flag_reg <= 1'b0;
      end else if (power_on_event || watchdog_clear_instruction || sleep_instruction) begin
        watchdog_expiry_flag_reg <= 1'b1;
      end
      if (sleep_instruction) begin
        power_down_flag_reg <= 1'b0;
      end else if (power_on_event || watchdog_clear_instruction) begin
        power_down_flag_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    reset_cause_control_read = 8'h00;
    reset_cause_control_read[rcwd_pkg::BIT_IRQ_PRIO] = irq_prio_reg;
    reset_cause_control_read[rcwd_pkg::BIT_SOFT_BOR] =
      (brownout_config == rcwd_pkg::BOR_CFG_SOFTWARE) && soft_bor_reg;
    reset_cause_control_read[rcwd_pkg::BIT_RESET_INSTR] = reset_instr_flag_reg;
    reset_cause_control_read[rcwd_pkg::BIT_WDOG_EXPIRY] = watchdog_expiry_flag_reg;
    reset_cause_control_read[rcwd_pkg::BIT_POWER_DOWN] = power_down_flag_reg;
    reset_cause_control_read[rcwd_pkg::BIT_POWER_ON] = power_on_flag_reg;
    reset_cause_control_read[rcwd_pkg::BIT_BROWNOUT] = brownout_flag_reg;
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          rcwd_pkg::ADDR_RESET_CAUSE: reg_rdata <= reset_cause_control_read;
          rcwd_pkg::ADDR_WAKE_STATUS: reg_rdata <= {5'h00, cpu_run,
            internal_osc_stable, primary_clock_ready};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign after_src = rcwd_pkg::rcwd_src_t'(src_after);

  // CPU preparation delay runs beside any oscillator wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_cnt_reg <= 6'h00;
      cpu_run <= 1'b1;
    end else if (ce) begin
      if (wake_event) begin
        cpu_cnt_reg <= 6'(rcwd_pkg::CPU_READY_CYCLES);
        cpu_run <= 1'b0;
      end else if (cpu_cnt_reg != 6'h00) begin
        cpu_cnt_reg <= cpu_cnt_reg - 6'h01;
        cpu_run <= cpu_cnt_reg == 6'h01;
      end
    end
  end

  // Oscillator wait sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rcwd_pkg::RCWD_ST_IDLE;
      primary_clock_ready <= 1'b0;
      internal_osc_stable <= 1'b0;
      dly.load <= 1'b0;
      dly.count <= 20'h0_0000;
    end else if (ce) begin
      dly.load <= 1'b0;
      case (state_reg)
        rcwd_pkg::RCWD_ST_IDLE: begin
          if (wake_event) begin
            if (primary_idle_mode) begin
              state_reg <= rcwd_pkg::RCWD_ST_DONE;
            end else if (after_src == rcwd_pkg::RCWD_SRC_CRYSTAL
                         || after_src == rcwd_pkg::RCWD_SRC_CRYSTAL_PLL) begin
              primary_clock_ready <= 1'b0;
              dly.load <= 1'b1;
              dly.count <= 20'(rcwd_pkg::OST_CYCLES - 1);
              state_reg <= rcwd_pkg::RCWD_ST_OST;
            end else if (after_src == rcwd_pkg::RCWD_SRC_INT_OSC
                         && src_before != 3'(rcwd_pkg::RCWD_SRC_INT_OSC)) begin
              internal_osc_stable <= 1'b0;
              dly.load <= 1'b1;
              dly.count <= 20'(rcwd_pkg::IOSC_STABLE_CYCLES - 1);
              state_reg <= rcwd_pkg::RCWD_ST_IOSC;
            end else begin
              state_reg <= rcwd_pkg::RCWD_ST_DONE;
            end
          end
        end
        rcwd_pkg::RCWD_ST_OST: begin
          if (dly.expired) begin
            if (after_src == rcwd_pkg::RCWD_SRC_CRYSTAL_PLL) begin
              dly.load <= 1'b1;
              dly.count <= 20'(rcwd_pkg::PLL_LOCK_CYCLES - 1);
              state_reg <= rcwd_pkg::RCWD_ST_PLL;
            end else begin
              primary_clock_ready <= 1'b1;
              state_reg <= rcwd_pkg::RCWD_ST_DONE;
            end
          end
        end
        rcwd_pkg::RCWD_ST_PLL: begin
          if (dly.expired) begin
            primary_clock_ready <= 1'b1;
            state_reg <= rcwd_pkg::RCWD_ST_DONE;
          end
        end
        rcwd_pkg::RCWD_ST_IOSC: begin
          if (dly.expired) begin
            internal_osc_stable <= 1'b1;
            state_reg <= rcwd_pkg::RCWD_ST_DONE;
          end
        end
        rcwd_pkg::RCWD_ST_DONE: state_reg <= rcwd_pkg::RCWD_ST_IDLE;
        default: state_reg <= rcwd_pkg::RCWD_ST_IDLE;
      endcase
    end
  end

  // Registered copies for outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_brownout_enable <= 1'b0;
      irq_priority_enable <= 1'b0;
      device_reset_req <= 1'b0;
      reset_cause_onehot <= 8'h00;
    end else if (ce) begin
      soft_brownout_enable <= soft_bor_en;
      irq_priority_enable <= irq_prio_reg;
      device_reset_req <= cause_next != 8'h00;
      reset_cause_onehot <= cause_reg;
    end
  end
endmodule // rcwd_top

// File: rcwd_monitor.sv
/*
  Concurrent checks on the reset cause and wake delay block.
  Sees only top-level ports; bound from the testbench file.
*/
`timescale 1ns/10ps
module rcwd_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] brownout_config,
  // Events and pin
  input wire logic reset_instr_event,
  input wire logic external_reset_pin_oe,
  input wire logic device_reset_req,
  // Wake sequencing
  input wire logic wake_event,
  input wire logic primary_idle_mode,
  input wire logic [2:0] src_after,
  input wire logic cpu_run,
  input wire logic primary_clock_ready,
  input wire logic soft_brownout_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [11:0] cnt_reg;
  logic xtal_reg;
  logic pll_reg;

  // Saturating count since the last sleep wake, so long lock waits stay visible
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 12'hFFF;
      xtal_reg <= 1'b0;
      pll_reg <= 1'b0;
    end else if (wake_event) begin
      cnt_reg <= 12'h000;
      xtal_reg <= !primary_idle_mode && src_after == rcwd_pkg::RCWD_SRC_CRYSTAL;
      pll_reg <= !primary_idle_mode && src_after == rcwd_pkg::RCWD_SRC_CRYSTAL_PLL;
    end else if (cnt_reg != 12'hFFF) begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  a_pin_never_driven: assert property (!external_reset_pin_oe)
    else $error("reset pin output enable went high");
  a_bit5_reads_zero: assert property ($past(reg_rd) |-> !reg_rdata[5])
    else $error("unimplemented bit read as one");
  a_bit6_cfg_gated: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0
    && $past(brownout_config) != 2'h1 |-> !reg_rdata[6])
    else $error("soft brown-out bit read as one outside software mode");
  a_sbor_out_gated: assert property (brownout_config == 2'h0 ##1
    brownout_config == 2'h0 |-> !soft_brownout_enable)
    else $error("soft brown-out enable high with brown-out disabled");
  a_wake_cpu_delay: assert property ($rose(wake_event) |=> !cpu_run [*8] ##1
    !cpu_run [*8] ##1 !cpu_run [*4] ##1 cpu_run)
    else $error("cpu delay after wake has wrong length");
  a_ost_full_count: assert property (xtal_reg && $rose(primary_clock_ready)
    |-> cnt_reg >= 12'd1022 && cnt_reg <= 12'd1031)
    else $error("crystal ready not after start-up count");
  a_pll_waits_lock: assert property (pll_reg && cnt_reg != 12'hFFF
    |-> !primary_clock_ready)
    else $error("pll target ready before lock wait");
  a_idle_keeps_ready: assert property ($rose(wake_event) && primary_idle_mode
    && primary_clock_ready |=> primary_clock_ready [*8])
    else $error("primary idle wake dropped clock ready");
  a_reset_req_follows: assert property ($rose(reset_instr_event) |=> device_reset_req)
    else $error("reset request missing after reset instruction");
endmodule // rcwd_monitor

// File: rcwd_reset_driver.sv
/*
  Board-side driver of the external reset pin.
  Assumes a pull-up, so the pin idles high when not pulled low.
*/
`timescale 1ns/10ps
module rcwd_reset_driver (
  // Clock
  input wire logic clk,
  // Pin
  output logic external_reset_pin
);
  initial external_reset_pin = 1'b1;

  // Holds the pin low for n whole clock cycles; callers pick lengths on either side of the filter
  task automatic hold_low(input int n);
    @(posedge clk);
    external_reset_pin <= 1'b0;
    repeat (n) @(posedge clk);
    external_reset_pin <= 1'b1;
  endtask
endmodule // rcwd_reset_driver

// File: testbench.sv
/*
  Self-checking bench for rcwd_top: register, event, pin and wake tests.
  Assumes the package constants and the board pin driver model.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] brownout_config = 2'h1;
  logic external_reset_pin_enable = 1'b1;
  logic [7:0] ev = 8'h00;
  logic power_managed = 1'b0;
  logic wake_event = 1'b0;
  logic primary_idle_mode = 1'b0;
  logic [2:0] src_before = 3'h0;
  logic [2:0] src_after = 3'h0;
  logic [7:0] reg_rdata, reset_cause_onehot, rd_val;
  logic drv_pin, external_reset_pin, external_reset_pin_out, external_reset_pin_oe;
  logic pin_digital_in, cpu_run, primary_clock_ready, internal_osc_stable, seen;
  logic soft_brownout_enable, irq_priority_enable, device_reset_req;
  logic [7:0] fexp [8] = '{8'h1C, 8'h1E, 8'h0F, 8'h17, 8'h1F, 8'h1F, 8'h1F, 8'h1B};
  int cbit [6] = '{0, 4, 5, 3, 6, 7};
  int fails = 0;
  int num_checks = 0;
  localparam int C = rcwd_pkg::CPU_READY_CYCLES;
  localparam int OSC_STARTUP_TIMER = rcwd_pkg::OST_CYCLES;
  localparam int IOS = rcwd_pkg::IOSC_STABLE_CYCLES;

  always #2.5 clk = ~clk;
  // Wire level: device only where it enables, else the board driver
  assign external_reset_pin = external_reset_pin_oe ? external_reset_pin_out : drv_pin;

  rcwd_top rcwd_top_inst (
    .clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .brownout_config, .external_reset_pin_enable, .power_on_event(ev[0]),
    .brownout_event(ev[1]), .reset_instr_event(ev[2]), .watchdog_timeout(ev[3]),
    .stack_full_event(ev[4]), .stack_underflow_event(ev[5]),
    .watchdog_clear_instruction(ev[6]), .sleep_instruction(ev[7]), .power_managed,
    .external_reset_pin, .external_reset_pin_out, .external_reset_pin_oe, .pin_digital_in,
    .wake_event, .primary_idle_mode, .src_before, .src_after, .cpu_run, .primary_clock_ready,
    .internal_osc_stable, .soft_brownout_enable, .irq_priority_enable, .device_reset_req,
    .reset_cause_onehot
  );
  rcwd_reset_driver rcwd_reset_driver_inst (.clk, .external_reset_pin(drv_pin));

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input string nm, input logic [1:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    check(nm, rd_val & m, e);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  // Measures cycles from the wake edge to cpu_run, then to the chosen ready flag
  task automatic wake(input logic [2:0] b, input logic [2:0] a, input logic idle,
                      input int sel, input int lo, input int hi);
    int n;
    int m;
    @(posedge clk);
    src_before <= b;
    src_after <= a;
    primary_idle_mode <= idle;
    power_managed <= 1'b1;
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    #1 n = 0;
    while (cpu_run !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    check("cpu ready delay", n >= C && n <= C + 2, 1);
    m = n;
    while ((sel == 1 ? primary_clock_ready : internal_osc_stable) !== 1'b1 && m < 3000) begin
      @(posedge clk);
      #1 m++;
    end
    check("clock ready delay", m >= lo && m <= hi, 1);
    power_managed <= 1'b0;
  endtask

  task automatic pin_low(input int len);
    seen = 1'b0;
    fork
      rcwd_reset_driver_inst.hold_low(len);
      repeat (len + 20) begin
        @(posedge clk);
        #1 seen = seen | device_reset_req;
      end
    join
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("cause reset value", 0, 8'hFF, 8'h5C);
    // Frozen clock enable must drop the write
    ce <= 1'b0;
    wr(0, 8'h80);
    ce <= 1'b1;
    rdchk("frozen write", 0, 8'h80, 8'h00);
    rdchk("unmapped read", 3, 8'hFF, 8'h00);
    wr(0, 8'hFF);
    rdchk("cause all set", 0, 8'hFF, 8'hDF);
    check("soft bor out", soft_brownout_enable, 1);
    check("priority out", irq_priority_enable, 1);
    wr(0, 8'h00);
    rdchk("flags only set", 0, 8'hFF, 8'h1F);
    brownout_config <= 2'h2;
    wr(0, 8'h40);
    rdchk("soft bor gated", 0, 8'h40, 8'h00);
    check("soft bor out hw mode", soft_brownout_enable, 1);
    brownout_config <= 2'h0;
    rdchk("soft bor off", 0, 8'h40, 8'h00);
    check("soft bor out off", soft_brownout_enable, 0);
    brownout_config <= 2'h1;
    for (int i = 0; i < 8; i++) begin
      // Software brown-out kept on so brown-out events count
      wr(0, 8'h53);
      pulse(6);
      pulse(i);
      repeat (12) @(posedge clk);
      rdchk("flags after event", 0, 8'h3F, fexp[i]);
      if (i < 6) check("cause capture", reset_cause_onehot[cbit[i]], 1);
    end
    wake(rcwd_pkg::RCWD_SRC_NONE, rcwd_pkg::RCWD_SRC_CRYSTAL, 0, 1, OSC_STARTUP_TIMER, OSC_STARTUP_TIMER + 6);
    wake(rcwd_pkg::RCWD_SRC_CRYSTAL, rcwd_pkg::RCWD_SRC_CRYSTAL, 1, 1, C, C + 2);
    wake(rcwd_pkg::RCWD_SRC_SECONDARY, rcwd_pkg::RCWD_SRC_EXT_CLOCK, 0, 1, C, C + 4);
    wake(rcwd_pkg::RCWD_SRC_NONE, rcwd_pkg::RCWD_SRC_INT_OSC, 0, 2, IOS, IOS + 6);
    wake(rcwd_pkg::RCWD_SRC_INT_OSC, rcwd_pkg::RCWD_SRC_INT_OSC, 0, 2, C, C + 2);
    wake(rcwd_pkg::RCWD_SRC_INT_31KHZ, rcwd_pkg::RCWD_SRC_CRYSTAL, 0, 1, OSC_STARTUP_TIMER, OSC_STARTUP_TIMER + 6);
    rdchk("wake status", 2, 8'hFF, 8'h07);
    pin_low(3);
    check("short pin pulse", seen, 0);
    for (int pm = 0; pm < 2; pm++) begin
      power_managed <= pm[0];
      pin_low(20);
      check("long pin pulse", seen, 1);
      check("pin cause", reset_cause_onehot[1 + pm], 1);
    end
    power_managed <= 1'b0;
    external_reset_pin_enable <= 1'b0;
    pin_low(20);
    check("disabled pin", seen, 0);
    check("pin as input", pin_digital_in, 1);
    check("pin driven level", external_reset_pin_out, 0);
    wake(rcwd_pkg::RCWD_SRC_NONE, rcwd_pkg::RCWD_SRC_CRYSTAL_PLL, 0, 1, 3000, 3000);
    give_verdict();
  end

  // Whole run is well under 20,000 cycles
  initial begin
    #200_000;
    fails++;
    give_verdict();
  end
endmodule // testbench

bind rcwd_top rcwd_monitor rcwd_monitor_inst (
  .clk, .nrst, .reg_addr, .reg_rd, .reg_rdata, .brownout_config, .reset_instr_event,
  .external_reset_pin_oe, .device_reset_req, .wake_event, .primary_idle_mode,
  .src_after, .cpu_run, .primary_clock_ready, .soft_brownout_enable
);
